// file: design/pdu_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module pdu_pin_ctrl
	import pdu_pkg::*;
#(
	parameter int          NPIN        = 4,
	parameter int          NKEY        = 32,
	parameter logic [7:0]  INS_DISABLE = 8'h26,
	parameter logic [7:0]  INS_ENABLE  = 8'h28,
	parameter logic [7:0]  INS_UNBLOCK = 8'h2C,
	parameter logic [63:0] PIN_DEFAULT = 64'h3132333435363738,
	parameter logic [63:0] UNB_DEFAULT = 64'h3837363534333231
) (
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	// Command from the terminal side
	input  wire logic                  cmd_valid_i,
	input  wire pdu_cmd_t              cmd_i,
	input  wire logic                  session_start_i,
	// Key verification results from the card controller
	input  wire logic [NKEY-1:0]       key_verified_i,
	// Answer
	output      pdu_rsp_t              rsp_o,
	output      logic                  busy_o,
	// PIN state
	output      logic [NPIN-1:0]       pin_enabled_o,
	output      logic [NPIN-1:0][3:0]  pin_tries_o,
	output      logic [NPIN-1:0][3:0]  unblk_tries_o,
	output      logic [NPIN-1:0][4:0]  repl_ref_o,
	output      logic [NPIN-1:0]       access_o,
	output      logic [NKEY-1:0][7:0]  key_qual_o
);

	localparam int IDXW = $clog2(NPIN);

	pdu_state_t       state_reg;
	pdu_cmd_t         cmd_reg;
	logic [IDXW-1:0]  idx;
	logic [4:0]       ref_m1;
	logic             ref_valid;
	logic             exec;
	logic [63:0]      pin_sel;
	logic [63:0]      unb_sel;
	logic             pin_match;
	logic             unb_match;
	logic [15:0]      sw_next;
	logic             dis_ok;
	logic             dis_bad;
	logic             en_ok;
	logic             en_bad;
	logic             unb_ok;
	logic             unb_bad;
	logic [63:0]      pin_reg [NPIN];
	logic [63:0]      unb_reg [NPIN];
	logic [NPIN-1:0]  verified_reg;

	// Sequencer: take one command, execute it on the next edge
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= PDU_ST_IDLE;
			busy_o    <= 1'b0;
			cmd_reg   <= '0;
		end else begin
			case (state_reg)
				PDU_ST_IDLE: begin
					if (cmd_valid_i) begin
						state_reg <= PDU_ST_EXEC;
						busy_o    <= 1'b1;
						cmd_reg   <= cmd_i;
					end
				end
				PDU_ST_EXEC: begin
					state_reg <= PDU_ST_IDLE;
					busy_o    <= 1'b0;
				end
				default: begin
					state_reg <= PDU_ST_IDLE;
					busy_o    <= 1'b0;
				end
			endcase
		end
	end

	assign exec = (state_reg == PDU_ST_EXEC);

	// PIN selection from P2
	assign ref_m1    = cmd_reg.p2[PDU_P_REF_MSB:0] - 5'h01;
	assign idx       = ref_m1[IDXW-1:0];
	assign ref_valid = pdu_ref_ok(cmd_reg.p2) &&
		(cmd_reg.p2[PDU_P_REF_MSB:0] <= 5'(NPIN));
	assign pin_sel   = pin_reg[idx];
	assign unb_sel   = unb_reg[idx];

	// Presented code against stored PIN and unblock code
	pdu_cmp u_cmp_pin (
		.given_i  (cmd_reg.code),
		.stored_i (pin_sel),
		.match_o  (pin_match)
	);

	pdu_cmp u_cmp_unb (
		.given_i  (cmd_reg.code),
		.stored_i (unb_sel),
		.match_o  (unb_match)
	);

	// Command decision and status word
	always_comb begin
		sw_next = PDU_SW_OK;
		dis_ok  = 1'b0;
		dis_bad = 1'b0;
		en_ok   = 1'b0;
		en_bad  = 1'b0;
		unb_ok  = 1'b0;
		unb_bad = 1'b0;
		if (!exec) begin
			sw_next = PDU_SW_OK;                                     // Decide only while executing
		end else if (cmd_reg.ins == INS_DISABLE) begin
			if (!ref_valid) begin
				sw_next = PDU_SW_REF;
			end else if (!((cmd_reg.p1 == PDU_P1_NONE) ||
				(cmd_reg.p1[PDU_P_FLAG_BIT] && pdu_ref_ok(cmd_reg.p1)))) begin
				sw_next = PDU_SW_PARAM;
			end else if (cmd_reg.lc != PDU_LC_PIN) begin
				sw_next = PDU_SW_LEN;
			end else if (pin_tries_o[idx] == 4'h0) begin
				sw_next = PDU_SW_BLOCKED;
			end else if (!pin_enabled_o[idx]) begin
				sw_next = PDU_SW_COND;
			end else if (pin_match) begin
				dis_ok = 1'b1;
			end else begin
				dis_bad = 1'b1;
				sw_next = PDU_SW_RETRY | {12'h000, pin_tries_o[idx] - 4'h1};
			end
		end else if (cmd_reg.ins == INS_ENABLE) begin
			if (!ref_valid) begin
				sw_next = PDU_SW_REF;
			end else if (cmd_reg.p1 != PDU_P1_NONE) begin
				sw_next = PDU_SW_PARAM;
			end else if (cmd_reg.lc != PDU_LC_PIN) begin
				sw_next = PDU_SW_LEN;
			end else if (pin_tries_o[idx] == 4'h0) begin
				sw_next = PDU_SW_BLOCKED;
			end else if (pin_enabled_o[idx]) begin
				sw_next = PDU_SW_COND;
			end else if (pin_match) begin
				en_ok = 1'b1;
			end else begin
				en_bad  = 1'b1;
				sw_next = PDU_SW_RETRY | {12'h000, pin_tries_o[idx] - 4'h1};
			end
		end else if (cmd_reg.ins == INS_UNBLOCK) begin
			if (!ref_valid) begin
				sw_next = PDU_SW_REF;
			end else if (cmd_reg.p1 != PDU_P1_NONE) begin
				sw_next = PDU_SW_PARAM;
			end else if (cmd_reg.lc == PDU_LC_EMPTY) begin
				sw_next = PDU_SW_RETRY | {12'h000, unblk_tries_o[idx]};
			end else if (cmd_reg.lc != PDU_LC_UNBLK) begin
				sw_next = PDU_SW_LEN;
			end else if (unblk_tries_o[idx] == 4'h0) begin
				sw_next = PDU_SW_BLOCKED;
			end else if (unb_match) begin
				unb_ok = 1'b1;
			end else begin
				unb_bad = 1'b1;
				sw_next = PDU_SW_RETRY | {12'h000, unblk_tries_o[idx] - 4'h1};
			end
		end else begin
			sw_next = PDU_SW_INS;
		end
	end

	// Answer: one-cycle valid after execution
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o.valid <= exec;
			if (exec) begin
				rsp_o.sw <= sw_next;
			end
		end
	end

	// Per-PIN state; reset stands in for loading the stored copy
	for (genvar g = 0; g < NPIN; g++) begin : g_pin
		logic hit;
		assign hit = exec && (idx == IDXW'(g));

		// Attempt counter
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				pin_tries_o[g] <= PDU_PIN_TRY_INIT;
			end else if (hit && (dis_ok || en_ok || unb_ok)) begin
				pin_tries_o[g] <= PDU_PIN_TRY_INIT;
			end else if (hit && (dis_bad || en_bad)) begin
				pin_tries_o[g] <= pin_tries_o[g] - 4'h1;
			end
		end

		// Enabled flag; wrong unblock leaves it alone
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				pin_enabled_o[g] <= 1'b1;
			end else if (hit && dis_ok) begin
				pin_enabled_o[g] <= 1'b0;
			end else if (hit && (en_ok || unb_ok)) begin
				pin_enabled_o[g] <= 1'b1;
			end
		end

		// Unblock counter and stored codes
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				unblk_tries_o[g] <= PDU_UNB_TRY_INIT;
				pin_reg[g]       <= PIN_DEFAULT;
				unb_reg[g]       <= UNB_DEFAULT;
			end else if (hit && unb_ok) begin
				unblk_tries_o[g] <= PDU_UNB_TRY_INIT;
				pin_reg[g]       <= cmd_reg.new_pin;
			end else if (hit && unb_bad) begin
				unblk_tries_o[g] <= unblk_tries_o[g] - 4'h1;
			end
		end

		// Replacement key in use for this PIN
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				repl_ref_o[g] <= 5'h00;
			end else if (hit && dis_ok) begin
				repl_ref_o[g] <= cmd_reg.p1[PDU_P_FLAG_BIT] ?
					cmd_reg.p1[PDU_P_REF_MSB:0] : 5'h00;
			end else if (hit && en_ok) begin
				repl_ref_o[g] <= 5'h00;
			end
		end

		// Access condition satisfied in this session
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i || session_start_i) begin
				verified_reg[g] <= 1'b0;
			end else if (hit && unb_ok) begin
				verified_reg[g] <= 1'b1;
			end
		end

		// Access: disabled PIN opens, or defers to the replacement key
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				access_o[g] <= 1'b0;
			end else if (!pin_enabled_o[g]) begin
				access_o[g] <= (repl_ref_o[g] == 5'h00) ? 1'b1 :
					key_verified_i[repl_ref_o[g]];
			end else begin
				access_o[g] <= verified_reg[g] && (pin_tries_o[g] != 4'h0);
			end
		end
	end

	// Usage qualifiers of the global key references
	for (genvar k = 0; k < NKEY; k++) begin : g_key
		always_ff @(posedge sys_clk_i) begin
			if (!rst_n_i) begin
				key_qual_o[k] <= PDU_QUAL_NONE;
			end else if (dis_ok && cmd_reg.p1[PDU_P_FLAG_BIT] &&
				(cmd_reg.p1[PDU_P_REF_MSB:0] == 5'(k))) begin
				key_qual_o[k] <= PDU_QUAL_USE;
			end else if (en_ok && (repl_ref_o[idx] == 5'(k)) &&
				(repl_ref_o[idx] != 5'h00)) begin
				key_qual_o[k] <= PDU_QUAL_NONE;
			end
		end
	end

	// Checks
	a_dis_restore: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		dis_ok |=> (pin_tries_o[$past(idx)] == PDU_PIN_TRY_INIT) &&
			!pin_enabled_o[$past(idx)] && rsp_o.valid && (rsp_o.sw == PDU_SW_OK))
		else $error("disable with correct PIN did not restore");

	a_dis_wrong: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		dis_bad |=> pin_enabled_o[$past(idx)] &&
			(pin_tries_o[$past(idx)] == $past(pin_tries_o[idx]) - 4'h1))
		else $error("wrong disable PIN not counted");

	a_dis_refuse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(exec && ref_valid && (cmd_reg.ins == INS_DISABLE) &&
			(!pin_enabled_o[idx] || (pin_tries_o[idx] == 4'h0))) |-> !dis_ok && !dis_bad)
		else $error("disable executed on disabled or blocked PIN");

	a_en_refuse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(exec && ref_valid && (cmd_reg.ins == INS_ENABLE) &&
			(pin_enabled_o[idx] || (pin_tries_o[idx] == 4'h0))) |-> !en_ok && !en_bad)
		else $error("enable executed on enabled or blocked PIN");

	a_qual_use: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(dis_ok && cmd_reg.p1[PDU_P_FLAG_BIT]) |=>
			(key_qual_o[$past(cmd_reg.p1[PDU_P_REF_MSB:0])] == PDU_QUAL_USE))
		else $error("replacement qualifier not set");

	a_unb_restore: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		unb_ok |=> (unblk_tries_o[$past(idx)] == PDU_UNB_TRY_INIT) &&
			(pin_tries_o[$past(idx)] == PDU_PIN_TRY_INIT) && pin_enabled_o[$past(idx)])
		else $error("unblock did not restore counters");

	a_unb_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		unb_bad |=> $stable(pin_enabled_o) && $stable(pin_tries_o))
		else $error("wrong unblock changed PIN state");

	a_unb_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(exec && ref_valid && (cmd_reg.ins == INS_UNBLOCK) && (cmd_reg.p1 == PDU_P1_NONE) &&
			(cmd_reg.lc == PDU_LC_UNBLK) && (unblk_tries_o[idx] == 4'h0))
			|=> rsp_o.valid && (rsp_o.sw == PDU_SW_BLOCKED))
		else $error("blocked unblock code not answered 6983");

	a_rsp_timing: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!busy_o && cmd_valid_i) |=> busy_o ##1 (rsp_o.valid && !busy_o))
		else $error("answer not two cycles after command");

	c_dis_ok: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) dis_ok);
	c_en_ok: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) en_ok);
	c_unb_lock: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		unb_bad && (unblk_tries_o[idx] == 4'h1));
	c_pin_block: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(dis_bad || en_bad) && (pin_tries_o[idx] == 4'h1));

endmodule : pdu_pin_ctrl

`default_nettype wire

// file: design/pdu_pkg.sv
package pdu_pkg;

	// Counter widths and initial values
	localparam int         PDU_TRY_W        = 4;
	localparam logic [3:0] PDU_PIN_TRY_INIT = 4'h3;
	localparam logic [3:0] PDU_UNB_TRY_INIT = 4'hA;

	// Usage qualifier values of a global key reference
	localparam logic [7:0] PDU_QUAL_USE  = 8'h08;
	localparam logic [7:0] PDU_QUAL_NONE = 8'h00;

	// Data field lengths
	localparam logic [7:0] PDU_LC_EMPTY = 8'h00;
	localparam logic [7:0] PDU_LC_PIN   = 8'h08;
	localparam logic [7:0] PDU_LC_UNBLK = 8'h10;

	// Parameter byte fields
	localparam int         PDU_P_FLAG_BIT = 7;
	localparam int         PDU_P_REF_MSB  = 4;
	localparam int         PDU_P_RFU_MSB  = 6;
	localparam int         PDU_P_RFU_LSB  = 5;
	localparam logic [7:0] PDU_P1_NONE    = 8'h00;

	// Status words
	localparam logic [15:0] PDU_SW_OK      = 16'h9000;
	localparam logic [15:0] PDU_SW_RETRY   = 16'h63C0;
	localparam logic [15:0] PDU_SW_BLOCKED = 16'h6983;
	localparam logic [15:0] PDU_SW_COND    = 16'h6985;
	localparam logic [15:0] PDU_SW_PARAM   = 16'h6A86;
	localparam logic [15:0] PDU_SW_REF     = 16'h6A88;
	localparam logic [15:0] PDU_SW_LEN     = 16'h6700;
	localparam logic [15:0] PDU_SW_INS     = 16'h6D00;

	// Command as taken from the terminal
	typedef struct packed {
		logic [7:0]  ins;
		logic [7:0]  p1;
		logic [7:0]  p2;
		logic [7:0]  lc;
		logic [63:0] code;
		logic [63:0] new_pin;
	} pdu_cmd_t;

	// Answer to the terminal
	typedef struct packed {
		logic        valid;
		logic [15:0] sw;
	} pdu_rsp_t;

	// Sequencer states
	typedef enum logic [0:0] {
		PDU_ST_IDLE,
		PDU_ST_EXEC
	} pdu_state_t;

	// Reference byte: RFU bits clear, number 01 to 1F
	function automatic logic pdu_ref_ok(input logic [7:0] p);
		pdu_ref_ok = (p[PDU_P_RFU_MSB:PDU_P_RFU_LSB] == 2'h0) &&
			(p[PDU_P_REF_MSB:0] != 5'h00);
	endfunction : pdu_ref_ok

endpackage : pdu_pkg

// file: design/pdu_cmp.sv
`timescale 1ns/1ps
`default_nettype none

// Compares a presented 8-byte code against stored reference data
module pdu_cmp (
	// Operands
	input  wire logic [63:0] given_i,
	input  wire logic [63:0] stored_i,
	// Result
	output      logic        match_o
);

	// Full-width equality, no early exit on the first byte
	assign match_o = ((given_i ^ stored_i) == 64'h0);

endmodule : pdu_cmp

`default_nettype wire

// file: bench/pdu_term.sv
`timescale 1ns/1ps
`default_nettype none

// Terminal side: offers one command at a time to the card
module pdu_term
	import pdu_pkg::*;
(
	// Clock and handshake
	input  wire logic     sys_clk_i,
	input  wire logic     busy_i,
	// Command toward the card
	output var  logic     cmd_valid_o,
	output var  pdu_cmd_t cmd_o
);
	// Idle at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
	end

	// Whole command held until taken, then fields scrambled
	task automatic send(input pdu_cmd_t c);
		int n;
		@(negedge sys_clk_i);
		cmd_o = c;
		cmd_valid_o = 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_i);
			if (busy_i === 1'b0)
				break;
		end
		@(negedge sys_clk_i);
		cmd_valid_o = 1'b0;
		cmd_o = ~c; // Released lines show no stale value
	endtask : send
endmodule : pdu_term
`default_nettype wire

// file: bench/pin_disable_enable_unblock_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pin_disable_enable_unblock_tb
	import pdu_pkg::*;
();
	localparam logic [63:0] PIN_A = 64'h3132333435363738;
	localparam logic [63:0] UNB_A = 64'h3837363534333231;
	localparam logic [7:0]  D     = 8'h26;
	localparam logic [7:0]  E     = 8'h28;
	localparam logic [7:0]  U     = 8'h2C;

	logic                 sys_clk_i       = 1'b0;
	logic                 rst_n_i         = 1'b0;
	logic                 session_start_i = 1'b0;
	logic [31:0]          key_verified_i  = 32'h0;
	logic                 cmd_valid_i;
	pdu_cmd_t             cmd_i;
	pdu_rsp_t             rsp_o;
	logic                 busy_o;
	logic [3:0]           pin_enabled_o;
	logic [3:0][3:0]      pin_tries_o;
	logic [3:0][3:0]      unblk_tries_o;
	logic [3:0][4:0]      repl_ref_o;
	logic [3:0]           access_o;
	logic [31:0][7:0]     key_qual_o;
	int                   failures    = 0;
	int                   comparisons = 0;
	int                   cycles      = 0;
	int                   k;
	logic [31:0]          seed        = 32'h7BF0;
	logic [63:0]          np;
	logic [15:0]          exp_q[$];

	// Clock, 10 ns period
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	pdu_pin_ctrl #(.PIN_DEFAULT(PIN_A), .UNB_DEFAULT(UNB_A)) pdu_pin_ctrl_inst (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i), .session_start_i(session_start_i), .key_verified_i(key_verified_i),
		.rsp_o(rsp_o), .busy_o(busy_o), .pin_enabled_o(pin_enabled_o),
		.pin_tries_o(pin_tries_o), .unblk_tries_o(unblk_tries_o), .repl_ref_o(repl_ref_o),
		.access_o(access_o), .key_qual_o(key_qual_o)
	);

	pdu_term pdu_term_inst (
		.sys_clk_i(sys_clk_i), .busy_i(busy_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i)
	);

	// Verdict and end of run
	task automatic report_and_stop;
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// Single comparison point
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Xorshift source
	function automatic logic [31:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : nxt

	// A code that surely differs from the given one
	function automatic logic [63:0] bad(input logic [63:0] v);
		return v ^ {nxt(), nxt() | 32'h1};
	endfunction : bad

	// One command, its status word noted for the watcher
	task automatic go(input logic [7:0] ins, input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] lc, input logic [63:0] code, input logic [15:0] sw);
		pdu_cmd_t c;
		int       n;
		c = '{ins: ins, p1: p1, p2: p2, lc: lc, code: code, new_pin: np};
		exp_q.push_back(sw);
		pdu_term_inst.send(c);
		for (n = 0; n < 8 && rsp_o.valid !== 1'b1; n++)
			@(negedge sys_clk_i);
		chk({31'h0, rsp_o.valid}, 32'h1);
		@(negedge sys_clk_i);
	endtask : go

	// State of one PIN
	task automatic st(input int i, input logic en, input logic [3:0] t, input logic [3:0] u,
		input logic acc);
		chk({31'h0, pin_enabled_o[i]}, {31'h0, en});
		chk({28'h0, pin_tries_o[i]}, {28'h0, t});
		chk({28'h0, unblk_tries_o[i]}, {28'h0, u});
		chk({31'h0, access_o[i]}, {31'h0, acc});
	endtask : st

	// Answer watcher and hang limit
	always @(negedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (rsp_o.valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk({16'h0, rsp_o.sw}, {16'h0, exp_q.pop_front()});
		end
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	// Main sequence
	initial begin
		np = 64'h0;
		repeat (6) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		@(negedge sys_clk_i);
		for (k = 0; k < 4; k++)
			st(k, 1'b1, 4'h3, 4'hA, 1'b0);
		for (k = 0; k < 32; k++)
			chk({24'h0, key_qual_o[k]}, 32'h0);
		// Refused commands leave state alone
		go(D, 8'h00, 8'h61, 8'h08, PIN_A, 16'h6A88);
		go(D, 8'h00, 8'h80, 8'h08, PIN_A, 16'h6A88);
		go(D, 8'h00, 8'h05, 8'h08, PIN_A, 16'h6A88);
		go(D, 8'h01, 8'h01, 8'h08, PIN_A, 16'h6A86);
		go(D, 8'hC5, 8'h01, 8'h08, PIN_A, 16'h6A86);
		go(D, 8'h00, 8'h01, 8'h07, PIN_A, 16'h6700);
		go(8'hB0, 8'h00, 8'h01, 8'h08, PIN_A, 16'h6D00);
		go(E, 8'h80, 8'h01, 8'h08, PIN_A, 16'h6A86);
		go(U, 8'h01, 8'h01, 8'h10, UNB_A, 16'h6A86);
		go(U, 8'h00, 8'h01, 8'h08, UNB_A, 16'h6700);
		go(E, 8'h00, 8'h81, 8'h08, PIN_A, 16'h6985);
		st(0, 1'b1, 4'h3, 4'hA, 1'b0);
		// Disable with replacement key 5
		go(D, 8'h00, 8'h01, 8'h08, bad(PIN_A), 16'h63C2);
		go(D, 8'h00, 8'h01, 8'h08, bad(PIN_A), 16'h63C1);
		st(0, 1'b1, 4'h1, 4'hA, 1'b0);
		go(D, 8'h85, 8'h01, 8'h08, PIN_A, 16'h9000);
		st(0, 1'b0, 4'h3, 4'hA, 1'b0);
		chk({24'h0, key_qual_o[5]}, 32'h8);
		chk({27'h0, repl_ref_o[0]}, 32'h5);
		key_verified_i = nxt() | 32'h20;
		repeat (2) @(negedge sys_clk_i);
		chk({31'h0, access_o[0]}, 32'h1);
		key_verified_i = nxt() & ~32'h20;
		repeat (2) @(negedge sys_clk_i);
		chk({31'h0, access_o[0]}, 32'h0);
		go(D, 8'h00, 8'h01, 8'h08, PIN_A, 16'h6985);
		go(E, 8'h00, 8'h01, 8'h08, bad(PIN_A), 16'h63C2);
		st(0, 1'b0, 4'h2, 4'hA, 1'b0);
		go(E, 8'h00, 8'h01, 8'h08, PIN_A, 16'h9000);
		st(0, 1'b1, 4'h3, 4'hA, 1'b0);
		chk({24'h0, key_qual_o[5]}, 32'h0);
		chk({27'h0, repl_ref_o[0]}, 32'h0);
		// Disabled PIN blocked by enable attempts
		go(D, 8'h00, 8'h02, 8'h08, PIN_A, 16'h9000);
		st(1, 1'b0, 4'h3, 4'hA, 1'b1);
		for (k = 0; k < 3; k++)
			go(E, 8'h00, 8'h02, 8'h08, bad(PIN_A), 16'h63C2 - 16'(k));
		st(1, 1'b0, 4'h0, 4'hA, 1'b1);
		go(E, 8'h00, 8'h02, 8'h08, PIN_A, 16'h6983);
		np = {nxt(), nxt()};
		go(U, 8'h00, 8'h02, 8'h10, UNB_A, 16'h9000);
		st(1, 1'b1, 4'h3, 4'hA, 1'b1);
		session_start_i = 1'b1;
		@(negedge sys_clk_i);
		session_start_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		st(1, 1'b1, 4'h3, 4'hA, 1'b0);
		go(D, 8'h00, 8'h02, 8'h08, np, 16'h9000);
		// Enabled PIN blocked by disable attempts
		for (k = 0; k < 3; k++)
			go(D, 8'h00, 8'h03, 8'h08, bad(PIN_A), 16'h63C2 - 16'(k));
		st(2, 1'b1, 4'h0, 4'hA, 1'b0);
		go(D, 8'h00, 8'h03, 8'h08, PIN_A, 16'h6983);
		go(U, 8'h00, 8'h03, 8'h00, 64'h0, 16'h63CA);
		go(U, 8'h00, 8'h03, 8'h10, bad(UNB_A), 16'h63C9);
		st(2, 1'b1, 4'h0, 4'h9, 1'b0);
		// Unblock code worn out
		for (k = 0; k < 10; k++)
			go(U, 8'h00, 8'h04, 8'h10, bad(UNB_A), 16'h63C9 - 16'(k));
		st(3, 1'b1, 4'h3, 4'h0, 1'b0);
		go(U, 8'h00, 8'h04, 8'h10, UNB_A, 16'h6983);
		go(U, 8'h00, 8'h04, 8'h00, 64'h0, 16'h63C0);
		// Second reset brings back the stored defaults
		rst_n_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		@(negedge sys_clk_i);
		st(3, 1'b1, 4'h3, 4'hA, 1'b0);
		go(U, 8'h00, 8'h04, 8'h10, UNB_A, 16'h9000);
		st(3, 1'b1, 4'h3, 4'hA, 1'b1);
		repeat (2) @(negedge sys_clk_i);
		report_and_stop();
	end
endmodule : pin_disable_enable_unblock_tb
`default_nettype wire
